//--- src/stx_decode.sv
// Decode and execute stage for store-word-right, system call, traps and exclusive-OR.
// Assumes operands already read from the register file and one clock with async reset.
`timescale 1ns/1ns
// Overview of operation
// - Store right index 0 little core: type 3, offset 0 or 4 by memory endian and address bit 2.
// - Store right writes word minus index bytes, register shifted up eight times index.
// - Address bit 2 xor core endian zero puts data low, else high half.
// - Byte index is low address bits xor core big-endian on both bits.
// - System call always raises its exception at once.
// - Code field of system call and traps is ignored.
// - Register greater-or-equal traps, signed and unsigned variants.
// - Unsigned immediate greater-or-equal trap uses sign-extended immediate.
// - Signed immediate less-than trap uses sign-extended immediate.
// - Unsigned register less-than trap.
// - Register not-equal trap.
// - Register exclusive-OR writes destination, no exception.
// - Immediate exclusive-OR zero-extends immediate, writes target, no exception.
// - Register-immediate class decoded by rt rows 20-19 and columns 18-16.
// - System coprocessor function decoded by rows 5-3 and columns 2-0.
// - Reserved decode entries raise a reserved instruction exception.
// - Unused system coprocessor functions execute as no-operation.
// - Doubleword coprocessor moves need kernel or 64-bit mode.
// - Coprocessor branch rt codes valid only under the branch rs class.
module stx_decode
   import stx_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic i_valid,
   input wire logic [31:0] i_insn,
   input wire logic [63:0] i_rs_val,
   input wire logic [63:0] i_rt_val,
   input wire logic [63:0] i_vaddr,
   input wire logic i_core_big_endian,
   input wire logic i_memory_big_endian,
   input wire logic i_kernel_or_64bit,
   input wire logic i_exc_ack,
   output logic o_ready,
   output logic o_wb_en,
   output logic [4:0] o_wb_reg,
   output logic [63:0] o_wb_data,
   output logic o_store_en,
   output logic [1:0] o_store_type,
   output logic [2:0] o_store_offset,
   output logic [63:0] o_store_data,
   output logic [3:0] o_exc,
   output logic [3:0] o_cp0_op,
   output logic o_cp0_en
);
   // ------------------------------------------------------------
   // Field extraction
   // ------------------------------------------------------------
   function automatic logic [63:0] sext16(input logic [15:0] imm);
      sext16 = {{48{imm[15]}}, imm};
   endfunction

   wire logic [5:0] op = i_insn[OP_MSB:OP_LSB];
   wire logic [4:0] rs_f = i_insn[25:21];
   wire logic [4:0] rt_f = i_insn[20:16];
   wire logic [4:0] rd_f = i_insn[15:11];
   wire logic [5:0] fn = i_insn[5:0];
   wire logic [15:0] imm = i_insn[15:0];
   wire logic [63:0] imm_sx = sext16(imm);
   wire logic [63:0] imm_zx = {48'h0, imm};
   wire logic is_special = (op == OP_SPECIAL);
   wire logic is_register_immediate_class = (op == OP_REGISTER_IMMEDIATE_CLASS);
   wire logic is_cop = (op == OP_SYSTEM_COPROCESSOR) || (op == OP_COP1) || (op == OP_COP2);

   // ------------------------------------------------------------
   // Trap compares
   // ------------------------------------------------------------
   // code ignored: register traps and system call never read bits 25-6.
   wire logic ge_s = $signed(i_rs_val) >= $signed(i_rt_val);
   wire logic ge_u = i_rs_val >= i_rt_val;
   wire logic lt_s = !ge_s;
   wire logic lt_u = !ge_u;
   wire logic ne = i_rs_val != i_rt_val;
   wire logic gei_s = $signed(i_rs_val) >= $signed(imm_sx);
   wire logic gei_u = i_rs_val >= imm_sx;
   wire logic lti_s = $signed(i_rs_val) < $signed(imm_sx);
   wire logic lti_u = i_rs_val < imm_sx;

   wire logic sp_trap = is_special && (
      ((fn == FN_TGE) && ge_s) || ((fn == FN_TRAP_GE_UNSIGNED_INSN) && ge_u) ||
      ((fn == FN_TLT) && lt_s) || ((fn == FN_TRAP_LT_UNSIGNED_INSN) && lt_u) ||
      ((fn == FN_TEQ) && !ne) || ((fn == FN_TNE) && ne));
   wire logic sp_known = (fn == FN_TGE) || (fn == FN_TRAP_GE_UNSIGNED_INSN) || (fn == FN_TLT) ||
      (fn == FN_TRAP_LT_UNSIGNED_INSN) || (fn == FN_TEQ) || (fn == FN_TNE) ||
      (fn == FN_SYSTEM_CALL_INSN) || (fn == FN_XOR);

   // ------------------------------------------------------------
   // Register-immediate map
   // ------------------------------------------------------------
   // row and column decode
   wire logic [1:0] ri_row = rt_f[4:3];
   wire logic [2:0] ri_col = rt_f[2:0];
   wire logic ri_branch = (ri_row == 2'h0 || ri_row == 2'h2) && !ri_col[2];
   wire logic ri_trap_row = (ri_row == 2'h1) && (ri_col != 3'h5) && (ri_col != 3'h7);
   logic ri_trap;
   always_comb begin
      case (ri_col)
         3'h0: ri_trap = gei_s;
         3'h1: ri_trap = gei_u;
         3'h2: ri_trap = lti_s;
         3'h3: ri_trap = lti_u;
         3'h4: ri_trap = (i_rs_val == imm_sx);
         3'h6: ri_trap = (i_rs_val != imm_sx);
         default: ri_trap = 1'b0;
      endcase
   end
   wire logic ri_resv = is_register_immediate_class && !ri_branch && !ri_trap_row;

   // ------------------------------------------------------------
   // Coprocessor maps
   // ------------------------------------------------------------
   wire logic [1:0] cr_row = rs_f[4:3];
   wire logic [2:0] cr_col = rs_f[2:0];
   wire logic cop_dmove = (cr_row == 2'h0) && (cr_col == 3'h1 || cr_col == 3'h5);
   wire logic cop_move = (cr_row == 2'h0) && (cr_col[1:0] != 2'h3);
   wire logic cop_bc = (cr_row == 2'h1) && (cr_col == 3'h0);
   wire logic cop_co = (cr_row == 2'h2) || (cr_row == 2'h3);
   // branch codes only under branch class
   wire logic bc_ok = cop_bc && (rt_f[4:2] == 3'h0);
   wire logic dmove_bad = cop_dmove && !i_kernel_or_64bit;
   wire logic cop_resv = is_cop && (dmove_bad || (!cop_move && !cop_co && !bc_ok));

   wire logic [2:0] cf_row = fn[5:3];
   wire logic [2:0] cf_col = fn[2:0];
   logic [3:0] cp0_kind;
   always_comb begin
      cp0_kind = CP0_NOP;
      if (cf_row == ROW_0 && cf_col == CP0_TRANSLATION_READ_INSN) begin
         cp0_kind = CP0_TRD;
      end else if (cf_row == ROW_0 && cf_col == CP0_TRANSLATION_WRITE_INDEXED_INSN) begin
         cp0_kind = CP0_TWI;
      end else if (cf_row == ROW_0 && cf_col == CP0_TRANSLATION_WRITE_RANDOM_INSN) begin
         cp0_kind = CP0_TWR;
      end else if (cf_row == ROW_1 && cf_col == CP0_TRANSLATION_PROBE_INSN) begin
         cp0_kind = CP0_TPRB;
      end else if (cf_row == ROW_3 && cf_col == CP0_EXCEPTION_RETURN_INSN) begin
         cp0_kind = CP0_XRET;
      end else if (cf_row == ROW_3 && cf_col == CP0_DEBUG_RETURN_INSN) begin
         cp0_kind = CP0_DRET;
      end else if (cf_row == ROW_4 && cf_col == CP0_WAIT) begin
         cp0_kind = CP0_WAITI;
      end
   end
   wire logic cp0_fn = (op == OP_SYSTEM_COPROCESSOR) && cop_co && (cp0_kind != CP0_NOP);

   // ------------------------------------------------------------
   // Store-word-right merge
   // ------------------------------------------------------------
   // byte index
   wire logic [1:0] sw_byte = i_vaddr[1:0] ^ {2{i_core_big_endian}};
   wire logic [31:0] sw_word = i_rt_val[31:0] << {sw_byte, 3'h0};
   wire logic sw_hi = i_vaddr[2] ^ i_core_big_endian;
   wire logic [63:0] sw_data = sw_hi ? {sw_word, 32'h0} : {32'h0, sw_word};
   wire logic [1:0] sw_type = WORD_BYTES_M1 - sw_byte;
   wire logic [2:0] sw_off = i_memory_big_endian ? {!sw_hi, 2'h0} : {sw_hi, sw_byte};
   wire logic is_swr = (op == OP_SWR);

   // ------------------------------------------------------------
   // Outcome
   // ------------------------------------------------------------
   wire logic is_system_call_insn = is_special && (fn == FN_SYSTEM_CALL_INSN);
   wire logic is_xor = is_special && (fn == FN_XOR);
   wire logic is_exclusive_or_imm_insn = (op == OP_EXCLUSIVE_OR_IMM_INSN);
   wire logic sp_resv = is_special && !sp_known;
   logic [3:0] exc_kind;
   always_comb begin
      if (is_system_call_insn) begin
         exc_kind = EXC_SYSTEM_CALL_INSN;
      end else if (sp_trap || (is_register_immediate_class && ri_trap_row && ri_trap)) begin
         exc_kind = EXC_TRAP;
      end else if (ri_resv || cop_resv || sp_resv) begin
         exc_kind = EXC_RESERVED;
      end else begin
         exc_kind = EXC_NONE;
      end
   end

   stx_state_type state;
   stx_state_type next_state;
   wire logic take = (state != ST_FLUSH) && i_valid;
   wire logic fault = take && (exc_kind != EXC_NONE);
   always_comb begin
      case (state)
         ST_IDLE: next_state = fault ? ST_FLUSH : (i_valid ? ST_ISSUE : ST_IDLE);
         ST_ISSUE: next_state = fault ? ST_FLUSH : (i_valid ? ST_ISSUE : ST_IDLE);
         ST_FLUSH: next_state = i_exc_ack ? ST_IDLE : ST_FLUSH;
         default: next_state = ST_IDLE;
      endcase
   end
   wire logic go = i_valid && (state != ST_FLUSH) && (exc_kind == EXC_NONE);
   wire logic next_ready = (next_state != ST_FLUSH);

   wire logic [63:0] xor_r = i_rs_val ^ i_rt_val;
   wire logic [63:0] xor_i = i_rs_val ^ imm_zx;

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // no write or store on fault, younger held
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_ready <= 1'b1;
         o_wb_en <= 1'b0;
         o_wb_reg <= 5'h0;
         o_wb_data <= DATA_RST;
         o_store_en <= 1'b0;
         o_store_type <= 2'h0;
         o_store_offset <= 3'h0;
         o_store_data <= DATA_RST;
         o_exc <= EXC_NONE;
         o_cp0_op <= CP0_NOP;
         o_cp0_en <= 1'b0;
      end else begin
         o_ready <= next_ready;
         o_wb_en <= go && (is_xor || is_exclusive_or_imm_insn);
         o_wb_reg <= is_xor ? rd_f : rt_f;
         o_wb_data <= is_xor ? xor_r : xor_i;
         o_store_en <= go && is_swr;
         o_store_type <= sw_type;
         o_store_offset <= sw_off;
         o_store_data <= sw_data;
         o_exc <= (i_valid && state != ST_FLUSH) ? exc_kind : EXC_NONE;
         o_cp0_op <= cp0_kind;
         o_cp0_en <= go && cp0_fn;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   sequence s_fault;
      i_valid && state != ST_FLUSH && exc_kind != EXC_NONE;
   endsequence
   sequence s_silent;
      !o_wb_en && !o_store_en;
   endsequence
   chk_system_call_insn_raise: assert property (
      (i_valid && state != ST_FLUSH && is_system_call_insn) |=> o_exc == EXC_SYSTEM_CALL_INSN)
      else $error("System call did not raise its exception.");
   chk_fault_silent: assert property (
      s_fault |=> s_silent ##1 (!o_wb_en && !o_store_en))
      else $error("Faulting instruction wrote or stored.");
   chk_swr_type: assert property (
      go && is_swr |=> o_store_type == 2'(3 - $past(sw_byte)))
      else $error("Store type does not match byte index.");
   chk_swr_offset: assert property (
      go && is_swr && !i_core_big_endian && i_vaddr[1:0] == 2'h0 && i_memory_big_endian
      |=> o_store_offset == {~$past(i_vaddr[2]), 2'h0})
      else $error("Big-endian memory offset wrong.");
   chk_swr_index: assert property (
      go && is_swr && i_core_big_endian && i_vaddr[1:0] == 2'h0 |=> o_store_type == 2'h0)
      else $error("Byte index wrong.");
   chk_swr_half: assert property (
      go && is_swr && !(i_vaddr[2] ^ i_core_big_endian) |=> o_store_data[63:32] == 32'h0)
      else $error("Store data in wrong half.");
   chk_trap_ne: assert property (
      i_valid && state != ST_FLUSH && is_special && fn == FN_TNE && ne
      |=> o_exc == EXC_TRAP)
      else $error("Not-equal trap missed.");
   chk_trap_geu: assert property (
      i_valid && state != ST_FLUSH && is_special && fn == FN_TRAP_GE_UNSIGNED_INSN && !ge_u
      |=> o_exc == EXC_NONE)
      else $error("Unsigned greater-or-equal trapped wrongly.");
   chk_xor_write: assert property (
      go && is_xor |=> o_wb_en && o_wb_data == $past(xor_r) && o_exc == EXC_NONE)
      else $error("Exclusive-OR result wrong.");
   chk_exclusive_or_imm_insn_zext: assert property (
      go && is_exclusive_or_imm_insn |=> o_wb_data[63:16] == $past(i_rs_val[63:16]))
      else $error("Immediate not zero-extended.");
   chk_flush_hold: assert property (
      state == ST_FLUSH && !i_exc_ack |=> !o_ready)
      else $error("Younger instruction accepted during exception.");
   chk_fault_stall: assert property (
      s_fault |=> !o_ready && state == ST_FLUSH)
      else $error("Fault did not stall the stage.");
endmodule

//--- src/stx_pkg.sv
// Constants and types for the store, trap and exclusive-OR decode stage.
// Assumes a 64-bit integer core fed one instruction word per valid cycle.
package stx_pkg;
   // ------------------------------------------------------------
   // Field positions and opcodes
   // ------------------------------------------------------------
   localparam int OP_MSB = 31;
   localparam int OP_LSB = 26;
   localparam logic [5:0] OP_SPECIAL = 6'h00;
   localparam logic [5:0] OP_REGISTER_IMMEDIATE_CLASS = 6'h01;
   localparam logic [5:0] OP_EXCLUSIVE_OR_IMM_INSN = 6'h0E;
   localparam logic [5:0] OP_SYSTEM_COPROCESSOR = 6'h10;
   localparam logic [5:0] OP_COP1 = 6'h11;
   localparam logic [5:0] OP_COP2 = 6'h12;
   localparam logic [5:0] OP_SWR = 6'h2E;
   localparam logic [5:0] FN_SYSTEM_CALL_INSN = 6'h0C;
   localparam logic [5:0] FN_XOR = 6'h26;
   localparam logic [5:0] FN_TGE = 6'h30;
   localparam logic [5:0] FN_TRAP_GE_UNSIGNED_INSN = 6'h31;
   localparam logic [5:0] FN_TLT = 6'h32;
   localparam logic [5:0] FN_TRAP_LT_UNSIGNED_INSN = 6'h33;
   localparam logic [5:0] FN_TEQ = 6'h34;
   localparam logic [5:0] FN_TNE = 6'h36;
   localparam logic [2:0] CP0_TRANSLATION_READ_INSN = 3'h1;
   localparam logic [2:0] CP0_TRANSLATION_WRITE_INDEXED_INSN = 3'h2;
   localparam logic [2:0] CP0_TRANSLATION_WRITE_RANDOM_INSN = 3'h6;
   localparam logic [2:0] CP0_TRANSLATION_PROBE_INSN = 3'h0;
   localparam logic [2:0] CP0_EXCEPTION_RETURN_INSN = 3'h0;
   localparam logic [2:0] CP0_DEBUG_RETURN_INSN = 3'h7;
   localparam logic [2:0] CP0_WAIT = 3'h0;
   localparam logic [2:0] ROW_0 = 3'h0;
   localparam logic [2:0] ROW_1 = 3'h1;
   localparam logic [2:0] ROW_3 = 3'h3;
   localparam logic [2:0] ROW_4 = 3'h4;
   // ------------------------------------------------------------
   // Store and reset values
   // ------------------------------------------------------------
   localparam logic [1:0] WORD_BYTES_M1 = 2'h3;
   localparam logic [2:0] BEM_HI_OFFSET = 3'h4;
   localparam logic [63:0] DATA_RST = 64'h0;
   // ------------------------------------------------------------
   // Result kinds
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      EXC_NONE = 4'h0,
      EXC_SYSTEM_CALL_INSN = 4'h1,
      EXC_TRAP = 4'h2,
      EXC_RESERVED = 4'h4,
      EXC_STORE = 4'h8
   } stx_exc_type;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ISSUE = 3'b010,
      ST_FLUSH = 3'b100
   } stx_state_type;
   typedef enum logic [3:0] {
      CP0_NOP = 4'h0,
      CP0_TRD = 4'h1,
      CP0_TWI = 4'h2,
      CP0_TWR = 4'h3,
      CP0_TPRB = 4'h4,
      CP0_XRET = 4'h5,
      CP0_DRET = 4'h6,
      CP0_WAITI = 4'h7
   } stx_cp0_type;
endpackage

//--- testbench/stx_exc_partner.sv
// Behavioural model of the exception logic that faces the decode stage.
// Assumes one clock shared with the decode stage and an active low async reset.
`timescale 1ns/1ns
module stx_exc_partner (
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic [3:0] i_exc,
   input wire logic [2:0] i_delay,
   output logic o_exc_ack
);
   logic busy;
   logic [2:0] cnt;
   // ------------------------------------------------------------
   // Acknowledge after a chosen delay
   // ------------------------------------------------------------
   // fault taken first.
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         busy <= 1'b0;
         cnt <= 3'h0;
         o_exc_ack <= 1'b0;
      end else begin
         o_exc_ack <= 1'b0;
         if (!busy && i_exc != 4'h0) begin
            busy <= 1'b1;
            cnt <= i_delay;
         end else if (busy && cnt == 3'h0) begin
            busy <= 1'b0;
            o_exc_ack <= 1'b1;
         end else if (busy) begin
            cnt <= cnt - 3'h1;
         end
      end
   end
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the store, trap and exclusive-OR decode stage.
// Assumes the partner model acknowledges every fault that the stage raises.
`timescale 1ns/1ns
module testbench;
   import stx_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, v = 1'b0, cbe = 1'b0, mbe = 1'b0, k64 = 1'b0, ack;
   logic [31:0] insn = 32'h0, seed = 32'h68A2, r;
   logic [63:0] rs = 64'h0, rt = 64'h0, va = 64'h0, q, a;
   logic [2:0] dly = 3'h0, o_store_offset, e_of = 3'h0;
   logic o_ready, o_wb_en, o_store_en, o_cp0_en, taken;
   logic e_wb = 1'b0, e_st = 1'b0, e_cp = 1'b0, e_off = 1'b0, e_all = 1'b1;
   logic [4:0] o_wb_reg, e_reg = 5'h0;
   logic [63:0] o_wb_data, o_store_data, e_wd = 64'h0, e_sd = 64'h0;
   logic [1:0] o_store_type, e_ty = 2'h0;
   logic [3:0] o_exc, o_cp0_op, e_exc = 4'h0, e_op = 4'h0;
   logic [31:0] tp [13] = '{32'h30, 32'h31, 32'h32, 32'h33, 32'h34, 32'h36, 32'h0C,
      32'h04080000, 32'h04090000, 32'h040A0000, 32'h040B0000, 32'h040C0000, 32'h040E0000};
   logic [31:0] rv [5] = '{32'h01, 32'h04180000, 32'h40200000, 32'h41080000, 32'h41010000};
   int err_total = 0, cmp_count = 0, stall = 0;
   always #5 clk = ~clk;
   stx_decode dut (.i_sys_clk(clk), .i_resetn(rstn), .i_valid(v), .i_insn(insn),
      .i_rs_val(rs), .i_rt_val(rt), .i_vaddr(va), .i_core_big_endian(cbe),
      .i_memory_big_endian(mbe), .i_kernel_or_64bit(k64), .i_exc_ack(ack),
      .o_ready(o_ready), .o_wb_en(o_wb_en), .o_wb_reg(o_wb_reg), .o_wb_data(o_wb_data),
      .o_store_en(o_store_en), .o_store_type(o_store_type), .o_store_offset(o_store_offset),
      .o_store_data(o_store_data), .o_exc(o_exc), .o_cp0_op(o_cp0_op), .o_cp0_en(o_cp0_en));
   stx_exc_partner partner (.i_sys_clk(clk), .i_resetn(rstn), .i_exc(o_exc), .i_delay(dly),
      .o_exc_ack(ack));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [63:0] rnd64();
      return {rnd(), rnd()};
   endfunction
   task automatic end_sim();
      if (err_total == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // ------------------------------------------------------------
   // Reference model
   // ------------------------------------------------------------
   task automatic calc(input logic tk, input logic [31:0] w, input logic [63:0] x, y, adr,
      input logic [2:0] md);
      logic [63:0] se;
      logic [1:0] by;
      logic [31:0] sh;
      logic t;
      se = {{48{w[15]}}, w[15:0]};
      t = 1'b0;
      e_exc = 4'h0;
      e_all = 1'b1;
      {e_wb, e_st, e_cp, e_off} = 4'h0;
      {e_reg, e_wd, e_sd, e_ty, e_of, e_op} = '0;
      if (tk) begin
         case (w[31:26])
            OP_SPECIAL: case (w[5:0])
               FN_SYSTEM_CALL_INSN: e_exc = EXC_SYSTEM_CALL_INSN;
               FN_XOR: {e_wb, e_reg, e_wd} = {1'b1, w[15:11], x ^ y};
               FN_TGE: t = $signed(x) >= $signed(y);
               FN_TRAP_GE_UNSIGNED_INSN: t = x >= y;
               FN_TLT: t = $signed(x) < $signed(y);
               FN_TRAP_LT_UNSIGNED_INSN: t = x < y;
               FN_TEQ: t = x == y;
               FN_TNE: t = x != y;
               default: e_exc = EXC_RESERVED;
            endcase
            OP_REGISTER_IMMEDIATE_CLASS: case (w[20:16])
               5'h08: t = $signed(x) >= $signed(se);
               5'h09: t = x >= se;
               5'h0A: t = $signed(x) < $signed(se);
               5'h0B: t = x < se;
               5'h0C: t = x == se;
               5'h0E: t = x != se;
               default: e_exc = EXC_RESERVED;
            endcase
            OP_EXCLUSIVE_OR_IMM_INSN: {e_wb, e_reg, e_wd} = {1'b1, w[20:16], x ^ {48'h0, w[15:0]}};
            OP_SYSTEM_COPROCESSOR: begin
               if (w[25]) begin
                  case (w[5:0])
                     6'h01: e_op = CP0_TRD;
                     6'h02: e_op = CP0_TWI;
                     6'h06: e_op = CP0_TWR;
                     6'h08: e_op = CP0_TPRB;
                     6'h18: e_op = CP0_XRET;
                     6'h1F: e_op = CP0_DRET;
                     6'h20: e_op = CP0_WAITI;
                     default: e_op = CP0_NOP;
                  endcase
                  e_cp = e_op != CP0_NOP;
               end else if (w[25:21] == 5'h01) begin
                  e_all = 1'b0;
                  if (!md[2]) e_exc = EXC_RESERVED;
               end else if (w[20:16] > 5'h03) begin
                  e_exc = EXC_RESERVED;
               end
            end
            OP_SWR: begin
               by = adr[1:0] ^ {2{md[0]}};
               sh = y[31:0] << (8 * by);
               {e_st, e_ty} = {1'b1, 2'h3 - by};
               e_sd = (adr[2] ^ md[0]) ? {sh, 32'h0} : {32'h0, sh};
               e_off = 1'b1;
               e_of = md[1] ? {~(adr[2] ^ md[0]), 2'h0} : (adr[2:0] ^ {3{md[0]}});
            end
            default: e_all = 1'b0;
         endcase
      end
      if (t) e_exc = EXC_TRAP;
   endtask
   task automatic check();
      chk(64'(o_exc), 64'(e_exc));
      if (e_all) chk(64'({o_wb_en, o_cp0_en}), 64'({e_wb, e_cp}));
      chk(64'(o_store_en), 64'(e_st));
      if (e_wb) chk(o_wb_data ^ 64'(o_wb_reg), e_wd ^ 64'(e_reg));
      if (e_st) chk(o_store_data, e_sd);
      if (e_st) chk(64'(o_store_type), 64'(e_ty));
      if (e_off) chk(64'(o_store_offset), 64'(e_of));
      if (e_cp) chk(64'(o_cp0_op), 64'(e_op));
      if (e_exc != 4'h0) chk(64'(o_ready), 64'h0);
      stall = (o_ready === 1'b1) ? 0 : stall + 1;
      if (stall > 20) begin
         err_total++;
         end_sim();
      end
   endtask
   task automatic step(input logic nv, input logic [31:0] w, input logic [63:0] x, y, adr,
      input logic [2:0] md);
      @(posedge clk);
      v <= nv;
      insn <= w;
      rs <= x;
      rt <= y;
      va <= adr;
      {k64, mbe, cbe} <= md;
      dly <= 3'(rnd());
      #1;
      check();
      taken = nv && (o_ready === 1'b1);
      calc(taken, w, x, y, adr, md);
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         step(1'b1, i[0] ? {OP_EXCLUSIVE_OR_IMM_INSN, r[25:0]} : {OP_SPECIAL, r[24:10], 5'h00, FN_XOR},
            rnd64(), rnd64(), 64'h0, 3'h0);
      end
      for (int i = 0; i < 32; i++) begin
         q = rnd64();
         step(1'b1, {OP_SWR, q[25:0]}, rnd64(), rnd64(), {q[63:3], 3'(i)}, {1'b0, 2'(i >> 3)});
      end
      for (int k = 0; k < 4; k++) begin
         for (int j = 0; j < 13; j++) begin
            r = rnd();
            q = rnd64();
            if (tp[j][31:26] == OP_REGISTER_IMMEDIATE_CLASS) r = tp[j] | {6'h0, r[4:0], 5'h0, r[20:5]};
            else r = tp[j] | {6'h0, r[19:0], 6'h0};
            a = (tp[j][31:26] == OP_REGISTER_IMMEDIATE_CLASS) ? {{48{r[15]}}, r[15:0]} : q;
            step(1'b1, r, k[0] ? a : rnd64(), q, 64'h0, 3'h0);
         end
      end
      for (int i = 0; i < 64; i++) begin
         r = rnd();
         step(1'b1, {OP_SYSTEM_COPROCESSOR, 5'h10, r[14:0], 6'(i)}, rnd64(), rnd64(), 64'h0, 3'h0);
      end
      for (int i = 0; i < 10; i++) begin
         step(1'b1, rv[i % 5], rnd64(), rnd64(), 64'h0, {i >= 5, 2'h0});
      end
      repeat (16) step(1'b0, 32'h0, 64'h0, 64'h0, 64'h0, 3'h0);
      end_sim();
   end
endmodule
